//--- design/rtca_defs.svh
// Constants of the alarm and calibration block: offsets, fields, resets.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word.
`ifndef RTCA_DEFS_SVH
`define RTCA_DEFS_SVH

// Register byte offsets
`define RTCA_OFF_WDHR 8'h00
`define RTCA_OFF_MINSEC 8'h04
`define RTCA_OFF_CFG 8'h08
`define RTCA_OFF_RPT 8'h0C
`define RTCA_OFF_CAL 8'h10
`define RTCA_OFF_MTHDY 8'h14

// Implemented bits of the alarm value registers
`define RTCA_WDHR_USED 16'h073F
`define RTCA_MINSEC_USED 16'h7F7F
`define RTCA_MTHDY_USED 16'h1F3F

// Alarm value field positions
`define RTCA_WDAY_LSB 8
`define RTCA_HR_LSB 0
`define RTCA_MIN_LSB 8
`define RTCA_SEC_LSB 0
`define RTCA_MTH_LSB 8
`define RTCA_DAY_LSB 0

// Alarm configuration field positions
`define RTCA_CFG_EN_BIT 7
`define RTCA_CFG_CHIME_BIT 14
`define RTCA_CFG_MASK_LSB 10

// Calibration register field positions
`define RTCA_CAL_WREN_BIT 8
`define RTCA_CAL_SYNC_BIT 9
`define RTCA_CAL_PULSE_BIT 10

// Reset values
`define RTCA_RST_VALUE 16'h0000
`define RTCA_RST_CAL 8'h00
`define RTCA_RST_RPT 8'h00

// Bus responses
`define RTCA_RESP_OKAY 2'h0
`define RTCA_RESP_SLVERR 2'h2

`endif

//--- design/rtca_pkg.sv
// Types shared by the alarm and calibration block.
// Assumes nothing of its surroundings.
package rtca_pkg;

    // Alarm interval selected by the mask field
    typedef enum logic [3:0] {
        RTCA_HALF_SEC = 4'b0000,
        RTCA_SEC      = 4'b0001,
        RTCA_TEN_SEC  = 4'b0010,
        RTCA_MINUTE   = 4'b0011,
        RTCA_TEN_MIN  = 4'b0100,
        RTCA_HOUR     = 4'b0101,
        RTCA_DAY      = 4'b0110,
        RTCA_WEEK     = 4'b0111,
        RTCA_MONTH    = 4'b1000,
        RTCA_YEAR     = 4'b1001
    } rtca_interval_t;

endpackage

//--- design/rtca_field_match.sv
// One BCD digit comparator of the alarm matcher.
// Assumes both digits are stable in the cycle where the match is used.
`timescale 1ns/1ps
`default_nettype none

module rtca_field_match #(
    parameter int W = 4
) (
    input wire logic enable,
    input wire logic [W-1:0] alarm_digit,
    input wire logic [W-1:0] time_digit,
    output logic match
);

    // A digit that the interval leaves out always matches
    assign match = !enable || (alarm_digit == time_digit);

    if (W < 1 || W > 4) begin : g_bad_width
        $error("rtca_field_match: a BCD digit is 1 to 4 bits wide");
    end

endmodule

`default_nettype wire

//--- design/rtca_alarm_cal.sv
// Alarm matcher, repeat counter and per-minute calibration of a BCD clock.
// Assumes time digits and tick pulses come from the timekeeping counters,
// synchronous to CLK, and the new time is on the digits in the tick cycle.
// Notes on behaviour
// - Weekday/hours alarm: weekday 10-8, hour tens 5-4, hour ones 3-0.
// - Minutes/seconds alarm: min tens 14-12, min ones 11-8, sec 6-4, 3-0.
// - Unused bits of all three alarm value registers read as zero.
// - Weekday/hours writes only land while clock write enable is one.
// - Each minute the signed calibration byte times four goes to the timer.
// - A negative calibration removes pulses; fast oscillator wants negative.
// - Alarm runs only while enable bit 7 is set; hardware clears it at end.
// - Mask field 13:10 picks which alarm digits must equal the clock.
// - Mask codes: half second, second, ten s, minute, up to year.
// - Yearly alarm on February 29 fires only when that date occurs.
// - Repeat count zero and chime off give exactly one alarm.
// - Repeat count FFh gives 255 extra alarms, the most possible.
// - Each alarm decrements the count; at zero, last alarm clears enable.
// - With chime set, count wraps from 00 to FF and alarms forever.
// - Every alarm, repeats included, raises the alarm interrupt.
// - Alarm pulse output toggles on each alarm, synchronous to the clock.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rtca_defs.svh"

module rtca_alarm_cal #(
    parameter int RPT_W = 8
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic SEC_TICK,
    input wire logic HALF_SEC_TICK,
    input wire logic [6:0] CUR_SECONDS,
    input wire logic [6:0] CUR_MINUTES,
    input wire logic [5:0] CUR_HOURS,
    input wire logic [2:0] CUR_WEEKDAY,
    input wire logic [5:0] CUR_DAY,
    input wire logic [4:0] CUR_MONTH,
    input wire logic CLOCK_SYNC_STATUS,
    output logic ALARM_IRQ,
    output logic ALARM_PULSE,
    output logic CAL_APPLY,
    output logic [9:0] CAL_PULSES
);
    import rtca_pkg::*;
    if (RPT_W < 1 || RPT_W > 8) begin : g_bad_rpt
        $error("rtca_alarm_cal: repeat count is 1 to 8 bits wide");
    end
    // Bus side state
    logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [15:0] wdata_reg;
    logic [1:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    // Register contents
    logic [15:0] wdhr_reg, minsec_reg, mthdy_reg;
    logic [7:0] cal_reg;
    logic clock_write_enable_reg;
    logic alarm_enable_reg, chime_reg;
    rtca_interval_t alarm_interval_mask_reg;
    logic [RPT_W-1:0] rpt_reg;
    logic irq_reg, pulse_reg, cal_apply_reg;
    logic [9:0] cal_pulses_reg;
    // Write decode: both halves of a write must be held before it lands
    logic wr_go, wr_wdhr, wr_minsec, wr_cfg, wr_rpt, wr_cal, wr_mthdy, wr_hit;
    logic [15:0] bm, cfg_rd, cal_rd;
    assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_wdhr = wr_go && aw_addr_reg == `RTCA_OFF_WDHR;
    assign wr_minsec = wr_go && aw_addr_reg == `RTCA_OFF_MINSEC;
    assign wr_cfg = wr_go && aw_addr_reg == `RTCA_OFF_CFG;
    assign wr_rpt = wr_go && aw_addr_reg == `RTCA_OFF_RPT;
    assign wr_cal = wr_go && aw_addr_reg == `RTCA_OFF_CAL;
    assign wr_mthdy = wr_go && aw_addr_reg == `RTCA_OFF_MTHDY;
    assign wr_hit = wr_wdhr | wr_minsec | wr_cfg | wr_rpt | wr_cal | wr_mthdy;
    assign bm = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    // Byte-merged write values; unimplemented bits never get stored
    logic [15:0] wdhr_next, minsec_next, mthdy_next, cfg_next, rpt_next, cal_next;
    assign wdhr_next = ((wdhr_reg & ~bm) | (wdata_reg & bm)) & `RTCA_WDHR_USED;
    assign minsec_next = ((minsec_reg & ~bm) | (wdata_reg & bm)) & `RTCA_MINSEC_USED;
    assign mthdy_next = ((mthdy_reg & ~bm) | (wdata_reg & bm)) & `RTCA_MTHDY_USED;
    assign cfg_next = (cfg_rd & ~bm) | (wdata_reg & bm);
    assign rpt_next = ({{(16 - RPT_W){1'b0}}, rpt_reg} & ~bm) | (wdata_reg & bm);
    assign cal_next = (cal_rd & ~bm) | (wdata_reg & bm);
    // Readback views of the packed control registers
    assign cfg_rd = {1'b0, chime_reg, alarm_interval_mask_reg, 2'b00,
                     alarm_enable_reg, 7'h00};
    assign cal_rd = {5'h00, pulse_reg, CLOCK_SYNC_STATUS, clock_write_enable_reg, cal_reg};
    // Read decode
    logic [7:0] rd_addr;
    logic rd_hit;
    logic [15:0] rd_val;
    assign rd_addr = {S_AXI_ARADDR[7:2], 2'b00};
    assign rd_hit = rd_addr == `RTCA_OFF_WDHR || rd_addr == `RTCA_OFF_MINSEC ||
                    rd_addr == `RTCA_OFF_CFG || rd_addr == `RTCA_OFF_RPT ||
                    rd_addr == `RTCA_OFF_CAL || rd_addr == `RTCA_OFF_MTHDY;
    assign rd_val = (rd_addr == `RTCA_OFF_WDHR) ? wdhr_reg :
                    (rd_addr == `RTCA_OFF_MINSEC) ? minsec_reg :
                    (rd_addr == `RTCA_OFF_CFG) ? cfg_rd :
                    (rd_addr == `RTCA_OFF_RPT) ? {{(16 - RPT_W){1'b0}}, rpt_reg} :
                    (rd_addr == `RTCA_OFF_CAL) ? cal_rd :
                    (rd_addr == `RTCA_OFF_MTHDY) ? mthdy_reg : 16'h0000;
    assign S_AXI_AWREADY = !aw_full_reg;
    assign S_AXI_WREADY = !w_full_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = !rvalid_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
    // Write address and data held independently, released together
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (S_AXI_AWVALID && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
        end else if (wr_go) begin
            aw_full_reg <= 1'b0;
        end
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            w_full_reg <= 1'b0;
            wdata_reg <= 16'h0000;
            wstrb_reg <= 2'b00;
        end else if (S_AXI_WVALID && !w_full_reg) begin
            w_full_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA[15:0]; // Upper lanes hold nothing
            wstrb_reg <= S_AXI_WSTRB[1:0];
        end else if (wr_go) begin
            w_full_reg <= 1'b0;
        end
    end
    // Write response; unmapped offsets answer SLVERR and change nothing
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `RTCA_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `RTCA_RESP_OKAY : `RTCA_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end
    // Read channel, one outstanding read
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `RTCA_RESP_OKAY;
        end else if (S_AXI_ARVALID && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {16'h0000, rd_val};
            rresp_reg <= rd_hit ? `RTCA_RESP_OKAY : `RTCA_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end
    // Alarm value registers; weekday/hours and month/day are write-locked
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wdhr_reg <= `RTCA_RST_VALUE;
            minsec_reg <= `RTCA_RST_VALUE;
            mthdy_reg <= `RTCA_RST_VALUE;
        end else begin
            if (wr_wdhr && clock_write_enable_reg) wdhr_reg <= wdhr_next;
            if (wr_minsec) minsec_reg <= minsec_next;
            if (wr_mthdy && clock_write_enable_reg) mthdy_reg <= mthdy_next;
        end
    end
    // Calibration byte and clock write enable
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cal_reg <= `RTCA_RST_CAL;
            clock_write_enable_reg <= 1'b0;
        end else if (wr_cal) begin
            cal_reg <= cal_next[7:0];
            clock_write_enable_reg <= cal_next[`RTCA_CAL_WREN_BIT];
        end
    end
    // Interval decode: from ten seconds up each step adds one digit group, except month swaps weekday for day
    logic [3:0] mask_code;
    logic mask_ok, tick, en_s1, en_s10, en_m1, en_m10, en_hr, en_wd, en_day, en_mth;
    assign mask_code = alarm_interval_mask_reg;
    assign mask_ok = mask_code <= RTCA_YEAR; // Codes above a year never fire
    assign tick = (alarm_interval_mask_reg == RTCA_HALF_SEC) ? HALF_SEC_TICK : SEC_TICK;
    assign en_s1 = mask_code >= RTCA_TEN_SEC;
    assign en_s10 = mask_code >= RTCA_MINUTE;
    assign en_m1 = mask_code >= RTCA_TEN_MIN;
    assign en_m10 = mask_code >= RTCA_HOUR;
    assign en_hr = mask_code >= RTCA_DAY;
    assign en_wd = alarm_interval_mask_reg == RTCA_WEEK; // Weekly only
    assign en_day = mask_code >= RTCA_MONTH;
    // Month joins for a yearly alarm, so 02/29 waits for a leap day
    assign en_mth = alarm_interval_mask_reg == RTCA_YEAR;
    // Digit comparators, one per digit from seconds to weekday; month and day compared inline
    logic [7:0] m;
    rtca_field_match #(.W(4)) u_s1 (.enable(en_s1), .alarm_digit(minsec_reg[3:0]),
        .time_digit(CUR_SECONDS[3:0]), .match(m[0]));
    rtca_field_match #(.W(3)) u_s10 (.enable(en_s10), .alarm_digit(minsec_reg[6:4]),
        .time_digit(CUR_SECONDS[6:4]), .match(m[1]));
    rtca_field_match #(.W(4)) u_m1 (.enable(en_m1), .alarm_digit(minsec_reg[11:8]),
        .time_digit(CUR_MINUTES[3:0]), .match(m[2]));
    rtca_field_match #(.W(3)) u_m10 (.enable(en_m10), .alarm_digit(minsec_reg[14:12]),
        .time_digit(CUR_MINUTES[6:4]), .match(m[3]));
    rtca_field_match #(.W(4)) u_h1 (.enable(en_hr), .alarm_digit(wdhr_reg[3:0]),
        .time_digit(CUR_HOURS[3:0]), .match(m[4]));
    rtca_field_match #(.W(2)) u_h10 (.enable(en_hr), .alarm_digit(wdhr_reg[5:4]),
        .time_digit(CUR_HOURS[5:4]), .match(m[5]));
    rtca_field_match #(.W(3)) u_wd (.enable(en_wd), .alarm_digit(wdhr_reg[10:8]),
        .time_digit(CUR_WEEKDAY), .match(m[6]));
    logic [10:0] md_alarm, md_time;
    logic md_en_ok;
    assign md_alarm = {mthdy_reg[12:8], mthdy_reg[5:0]};
    assign md_time = {CUR_MONTH, CUR_DAY};
    assign md_en_ok = (!en_day || md_alarm[5:0] == md_time[5:0]) &&
                      (!en_mth || md_alarm[10:6] == md_time[10:6]);
    assign m[7] = md_en_ok;
    // Alarm event: enabled, a valid interval, the tick, every enabled digit equal
    logic fire, last_alarm;
    assign fire = alarm_enable_reg && mask_ok && tick && (&m);
    assign last_alarm = rpt_reg == '0 && !chime_reg;
    // Enable, chime and mask; a software write wins over the automatic clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            alarm_enable_reg <= 1'b0;
            chime_reg <= 1'b0;
            alarm_interval_mask_reg <= RTCA_HALF_SEC;
        end else if (wr_cfg) begin
            alarm_enable_reg <= cfg_next[`RTCA_CFG_EN_BIT];
            chime_reg <= cfg_next[`RTCA_CFG_CHIME_BIT];
            alarm_interval_mask_reg <= rtca_interval_t'(cfg_next[`RTCA_CFG_MASK_LSB +: 4]);
        end else if (fire && last_alarm) begin
            alarm_enable_reg <= 1'b0;
        end
    end
    // Repeat counter: down by one each alarm, wraps under chime
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rpt_reg <= RPT_W'(`RTCA_RST_RPT);
        end else if (wr_rpt) begin
            rpt_reg <= rpt_next[RPT_W-1:0];
        end else if (fire) begin
            if (rpt_reg != '0) rpt_reg <= rpt_reg - 1'b1;
            else if (chime_reg) rpt_reg <= '1;
        end
    end
    // Interrupt pulse and half-rate alarm output, both from flops
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            irq_reg <= fire;
            pulse_reg <= pulse_reg ^ fire;
        end
    end
    assign ALARM_IRQ = irq_reg;
    assign ALARM_PULSE = pulse_reg;
    // Minute boundary calibration; the timer adds or drops the signed amount
    logic minute_hit;
    assign minute_hit = SEC_TICK && CUR_SECONDS == 7'h00;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cal_apply_reg <= 1'b0;
            cal_pulses_reg <= 10'h000;
        end else begin
            cal_apply_reg <= minute_hit;
            if (minute_hit) cal_pulses_reg <= {cal_reg, 2'b00};
        end
    end
    assign CAL_APPLY = cal_apply_reg;
    assign CAL_PULSES = cal_pulses_reg;
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_final_alarm;
        fire && last_alarm && !wr_cfg;
    endsequence
    sequence s_counted_alarm;
        fire && rpt_reg != '0 && !wr_rpt;
    endsequence
    a_alarm_turns_off: assert property (s_final_alarm |=> !alarm_enable_reg)
        else $error("alarm stayed enabled after its final event");
    a_count_steps_down: assert property (s_counted_alarm
        |=> rpt_reg == $past(rpt_reg) - 1'b1)
        else $error("repeat count did not drop by one");
    a_chime_wraps: assert property (fire && rpt_reg == '0 && chime_reg && !wr_rpt && !wr_cfg
        |=> rpt_reg == '1 && alarm_enable_reg)
        else $error("chime did not wrap the repeat count");
    a_no_fire_disabled: assert property (!alarm_enable_reg |-> !fire)
        else $error("alarm fired while disabled");
    a_irq_per_alarm: assert property (fire
        |=> ALARM_IRQ ##1 (ALARM_IRQ == $past(fire)))
        else $error("alarm interrupt does not follow the event");
    a_pulse_toggle: assert property (fire |=> ALARM_PULSE != $past(ALARM_PULSE))
        else $error("alarm pulse did not toggle");
    a_pulse_steady: assert property (!fire |=> $stable(ALARM_PULSE))
        else $error("alarm pulse moved without an alarm");
    a_cal_scaled: assert property (minute_hit |=> CAL_APPLY
        && CAL_PULSES == {$past(cal_reg), 2'b00})
        else $error("calibration amount is not four times the byte");
    a_wdhr_locked: assert property (wr_wdhr && !clock_write_enable_reg
        |=> $stable(wdhr_reg))
        else $error("weekday and hours changed while write locked");
    a_unused_zero: assert property ((wdhr_reg & ~`RTCA_WDHR_USED) == 16'h0000
        && (minsec_reg & ~`RTCA_MINSEC_USED) == 16'h0000)
        else $error("unimplemented alarm bits are not zero");
    a_mask_ignores: assert property (alarm_enable_reg && alarm_interval_mask_reg == RTCA_SEC
        && SEC_TICK |-> fire)
        else $error("per-second alarm compared a masked digit");
endmodule

`default_nettype wire

//--- dv/rtca_alarm_cal_tb.sv
// Self-checking bench of the alarm matcher, repeat counter and calibration.
// Assumes the block alone: the bench plays the bus master and the time counters.
`timescale 1ns/1ps
`default_nettype none
`include "rtca_defs.svh"

module rtca_alarm_cal_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic sec_tick = 1'b0, half_tick = 1'b0;
    logic [6:0] cur_sec = 7'h30, cur_min = 7'h45;
    logic [5:0] cur_hr = 6'h15, cur_day = 6'h12;
    logic [2:0] cur_wd = 3'h3;
    logic [4:0] cur_mon = 5'h06;
    logic awready, wready, bvalid, arready, rvalid, irq, pulse, cal_apply;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [9:0] cal_pulses;
    logic sync_st = 1'b0;
    int bad_count = 0;
    int n_compared = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    // Sync status comes from the bench so its readback can be judged
    rtca_alarm_cal DUT (
        .CLK(clk), .RST_N(rst_n),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'h3), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .SEC_TICK(sec_tick),
        .HALF_SEC_TICK(half_tick), .CUR_SECONDS(cur_sec), .CUR_MINUTES(cur_min),
        .CUR_HOURS(cur_hr), .CUR_WEEKDAY(cur_wd), .CUR_DAY(cur_day), .CUR_MONTH(cur_mon),
        .CLOCK_SYNC_STATUS(sync_st), .ALARM_IRQ(irq), .ALARM_PULSE(pulse),
        .CAL_APPLY(cal_apply), .CAL_PULSES(cal_pulses)
    );

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Readies are sampled at the falling edge: stable until the taking edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        logic aw_hit, w_hit;
        logic b_hit = 1'b0;
        logic [1:0] r = 2'h3;
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hit) begin
            @(negedge clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk("write response", {30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
        logic ar_hit;
        logic r_hit = 1'b0;
        logic [31:0] d = 32'hFFFFFFFF;
        logic [1:0] r = 2'h3;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hit) begin
            @(negedge clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_hit) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk("read data", d, {16'h0000, ed});
        chk("read response", {30'h0, r}, {30'h0, er});
    endtask

    // One tick; alarm outputs are judged in the cycle after it is taken
    task automatic tick(input logic half_only, input logic exp);
        logic p0;
        p0 = pulse;
        @(posedge clk);
        half_tick <= 1'b1;
        sec_tick <= !half_only;
        @(posedge clk);
        half_tick <= 1'b0;
        sec_tick <= 1'b0;
        #1;
        chk("alarm irq", {31'h0, irq}, {31'h0, exp});
        chk("alarm pulse", {31'h0, pulse}, {31'h0, p0 ^ exp});
    endtask

    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), 16'h0000, `RTCA_RESP_OKAY);
        end
        rd(8'h18, 16'h0000, `RTCA_RESP_SLVERR);
        wr(8'h18, 16'hFFFF, `RTCA_RESP_SLVERR);
        $display("test reset done");
    endtask

    // Alarm values are only written here, with the alarm disabled
    task automatic t_lock();
        wr(`RTCA_OFF_WDHR, 16'hFFFF, `RTCA_RESP_OKAY);
        rd(`RTCA_OFF_WDHR, 16'h0000, `RTCA_RESP_OKAY);
        wr(`RTCA_OFF_CAL, 16'h0100, `RTCA_RESP_OKAY);
        wr(`RTCA_OFF_WDHR, 16'hFFFF, `RTCA_RESP_OKAY);
        rd(`RTCA_OFF_WDHR, 16'h073F, `RTCA_RESP_OKAY);
        wr(`RTCA_OFF_MINSEC, 16'hFFFF, `RTCA_RESP_OKAY);
        rd(`RTCA_OFF_MINSEC, 16'h7F7F, `RTCA_RESP_OKAY);
        wr(`RTCA_OFF_WDHR, 16'h0315, `RTCA_RESP_OKAY);
        wr(`RTCA_OFF_MINSEC, 16'h4530, `RTCA_RESP_OKAY);
        wr(`RTCA_OFF_MTHDY, 16'h0612, `RTCA_RESP_OKAY);
        rd(`RTCA_OFF_WDHR, 16'h0315, `RTCA_RESP_OKAY);
        rd(`RTCA_OFF_MINSEC, 16'h4530, `RTCA_RESP_OKAY);
        $display("test lock done");
    endtask

    // Most negative, small positive and minus one calibration values
    task automatic t_cal();
        logic [7:0] cv[3] = '{8'h80, 8'h05, 8'hFF};
        logic [9:0] ep[3] = '{10'h200, 10'h014, 10'h3FC};
        for (int i = 0; i < 3; i++) begin
            wr(`RTCA_OFF_CAL, {8'h01, cv[i]}, `RTCA_RESP_OKAY);
            @(posedge clk);
            cur_sec <= 7'h00;
            tick(1'b0, 1'b0);
            chk("cal apply", {31'h0, cal_apply}, 32'h1);
            chk("cal pulses", {22'h0, cal_pulses}, {22'h0, ep[i]});
            @(posedge clk);
            cur_sec <= 7'h30;
            tick(1'b0, 1'b0);
            chk("cal apply", {31'h0, cal_apply}, 32'h0);
        end
        $display("test calibration done");
    endtask

    task automatic t_masks();
        for (int m = 0; m < 16; m++) begin
            wr(`RTCA_OFF_CFG, 16'h0080 | 16'(m << 10), `RTCA_RESP_OKAY);
            tick(m == 0, m < 10);
            rd(`RTCA_OFF_CFG, 16'(m << 10) | ((m < 10) ? 16'h0 : 16'h80), 2'h0);
            wr(`RTCA_OFF_CFG, 16'h0000, `RTCA_RESP_OKAY);
        end
        wr(`RTCA_OFF_CFG, 16'h0C80, `RTCA_RESP_OKAY);
        tick(1'b1, 1'b0);
        wr(`RTCA_OFF_CFG, 16'h0000, `RTCA_RESP_OKAY);
        $display("test masks done");
    endtask

    // Disturb one digit group; only masks that compare it must stay quiet
    task automatic t_fields();
        logic [3:0] mk[8] = '{4'h5, 4'h6, 4'h6, 4'h7, 4'h8, 4'h9, 4'h1, 4'h2};
        int fld[8] = '{0, 0, 1, 1, 2, 2, 3, 3};
        logic ex[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            cur_hr <= (fld[i] == 0) ? 6'h16 : 6'h15;
            cur_wd <= (fld[i] == 1) ? 3'h4 : 3'h3;
            cur_mon <= (fld[i] == 2) ? 5'h07 : 5'h06;
            cur_sec <= (fld[i] == 3) ? 7'h31 : 7'h30;
            wr(`RTCA_OFF_CFG, {2'b00, mk[i], 10'h080}, `RTCA_RESP_OKAY);
            tick(1'b0, ex[i]);
            wr(`RTCA_OFF_CFG, 16'h0000, `RTCA_RESP_OKAY);
        end
        @(posedge clk);
        cur_hr <= 6'h15;
        cur_wd <= 3'h3;
        cur_mon <= 5'h06;
        cur_sec <= 7'h30;
        $display("test fields done");
    endtask

    // Count and chime are only written while sync status reads zero
    task automatic t_repeat();
        @(posedge clk);
        sync_st <= 1'b1;
        rd(`RTCA_OFF_CAL, 16'h03FF, `RTCA_RESP_OKAY);
        @(posedge clk);
        sync_st <= 1'b0;
        wr(`RTCA_OFF_RPT, 16'h0001, `RTCA_RESP_OKAY);
        wr(`RTCA_OFF_CFG, 16'h0C80, `RTCA_RESP_OKAY);
        tick(1'b0, 1'b1);
        // Fifteen alarms so far, so the pulse bit reads one
        rd(`RTCA_OFF_CAL, 16'h05FF, `RTCA_RESP_OKAY);
        rd(`RTCA_OFF_RPT, 16'h0000, `RTCA_RESP_OKAY);
        rd(`RTCA_OFF_CFG, 16'h0C80, `RTCA_RESP_OKAY);
        tick(1'b0, 1'b1);
        rd(`RTCA_OFF_CFG, 16'h0C00, `RTCA_RESP_OKAY);
        tick(1'b0, 1'b0);
        // Full count: 255 repeats plus the first alarm, then silence
        wr(`RTCA_OFF_RPT, 16'h00FF, `RTCA_RESP_OKAY);
        wr(`RTCA_OFF_CFG, 16'h0C80, `RTCA_RESP_OKAY);
        for (int k = 0; k < 256; k++) begin
            tick(1'b0, 1'b1);
        end
        tick(1'b0, 1'b0);
        wr(`RTCA_OFF_CFG, 16'h4C80, `RTCA_RESP_OKAY);
        tick(1'b0, 1'b1);
        rd(`RTCA_OFF_RPT, 16'h00FF, `RTCA_RESP_OKAY);
        rd(`RTCA_OFF_CFG, 16'h4C80, `RTCA_RESP_OKAY);
        tick(1'b0, 1'b1);
        rd(`RTCA_OFF_RPT, 16'h00FE, `RTCA_RESP_OKAY);
        wr(`RTCA_OFF_CFG, 16'h0000, `RTCA_RESP_OKAY);
        $display("test repeat done");
    endtask

    // Main sequence: reset held for 16 cycles, then the tests in order
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_lock();
        t_cal();
        t_masks();
        t_fields();
        t_repeat();
        wrap_up();
    end

    // Watchdog: the tests need about 1000 cycles, so 20000 is ample
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
